// file: dac_word_regs.svh
// Constants of the dual converter serial word decoder
`ifndef DAC_WORD_REGS_SVH
`define DAC_WORD_REGS_SVH
`define WORD_BITS 16
`define DATA_BITS 12
`define SELECT_HIGH_POS 15
`define SPEED_POS 14
`define POWER_POS 13
`define SELECT_LOW_POS 12
`define CODE_RESET 12'h000
`define COUNT_FULL 5'h10
`endif

// file: dac_word_pkg.sv
// Types shared by the serial word decoder files
package dac_word_pkg;
    typedef enum logic [1:0] {
        SEL_B_AND_BUF,
        SEL_BUF_ONLY,
        SEL_A_AND_XFER,
        SEL_RESERVED
    } select_t;
    typedef struct packed {
        logic [11:0] code;
        logic fast;
        logic power_down;
        select_t sel;
    } command_t;
endpackage : dac_word_pkg

// file: level_sync.sv
// Two-stage synchroniser for a level
`timescale 1ns/1ps
module level_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;
    sync_state_t state;
    sync_state_t next_state;

    // First stage feeds only the second
    always_comb begin
        next_state.s1 = d;
        next_state.s2 = state.s1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.s2;
endmodule : level_sync

// file: word_decode.sv
// Splits a received word into its command fields
`timescale 1ns/1ps
`include "dac_word_regs.svh"
module word_decode
    import dac_word_pkg::*;
(
    input wire logic [15:0] word,
    output command_t cmd
);
    // Field extraction, data most significant first
    always_comb begin
        cmd.code = word[`DATA_BITS-1:0];
        cmd.fast = word[`SPEED_POS];
        cmd.power_down = word[`POWER_POS];
        cmd.sel = select_t'({word[`SELECT_HIGH_POS], word[`SELECT_LOW_POS]});
    end
endmodule : word_decode

// file: dual_dac_serial_word_decoder.sv
// Serial command receiver and latch file of a dual converter
//
// Notes on behaviour
// - Word is 4 program plus 12 data bits
// - Data bits are output code, MSB first
// - Select 00 loads converter B and buffer
// - Select 01 loads the buffer only
// - Select 10 loads A, buffer goes to B
// - Speed bit one selects fast settling
// - Speed bit zero selects slow settling
// - A output applied second rising edge after D0
// - In select 10 both outputs change together after D0
// - Chip select falling starts, shift on fall
// - Sixteen bits or early rise loads latches
// - Power-on clears all latches to zero
`timescale 1ns/1ps
`include "dac_word_regs.svh"
module dual_dac_serial_word_decoder
    import dac_word_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic din,
    output logic [11:0] code_a,
    output logic [11:0] code_b,
    output logic fast_mode,
    output logic power_down,
    output logic update_toggle
);
    // ------------------------------------------------------------
    // Link side: bit shifting on the falling serial clock
    // ------------------------------------------------------------

    // Shift register and bit count of the frame in progress
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0] count;
    } shift_state_t;
    shift_state_t fs;
    shift_state_t next_fs;

    // Frame clear and the register shifted by one place
    logic frame_clear_b;
    logic [15:0] shifted;

    // Chip select high holds the frame cleared, clock running or not
    assign frame_clear_b = rst_b && !cs_b;

    // Each bit takes its lower neighbour; bit zero takes the pin
    for (genvar i = 0; i < `WORD_BITS; i++) begin : g_shift
        if (i == 0) begin : g_pin
            assign shifted[i] = din;
        end else begin : g_next
            assign shifted[i] = fs.shift[i-1];
        end
    end

    // One bit per falling edge, MSB first; later bits are ignored
    always_comb begin
        next_fs = fs;
        if (fs.count != `COUNT_FULL) begin
            next_fs.shift = shifted;
            next_fs.count = fs.count + 5'h01;
        end
    end

    // A new frame always starts from bit zero with an empty register
    always_ff @(negedge sclk or negedge frame_clear_b) begin
        if (!frame_clear_b) begin
            fs <= '0;
        end else begin
            fs <= next_fs;
        end
    end

    // ------------------------------------------------------------
    // Link side: frame completion on the rising serial clock
    // ------------------------------------------------------------

    // Latches of the link side; the held values cross to the system
    // clock while they stand still between words
    typedef struct packed {
        logic [15:0] shift_seen;
        logic [4:0] count_seen;
        logic load_pend;
        logic [15:0] word;
        logic [11:0] buffer;
        logic [11:0] hold_a;
        logic [11:0] hold_b;
        logic fast;
        logic pd;
        logic toggle;
    } link_state_t;
    link_state_t ls;
    link_state_t next_ls;

    // Completion flags and the word that a finished frame hands on
    logic frame_full;
    logic frame_cut;
    logic [15:0] frame_word;

    // Full frame: first rising edge that sees sixteen bits; cut frame:
    // chip select high after some bits but fewer than sixteen; a cut
    // frame still needs two rising serial clock edges to be applied
    always_comb begin
        frame_full = (fs.count == `COUNT_FULL)
            && (ls.count_seen != `COUNT_FULL);
        frame_cut = cs_b && (ls.count_seen != 5'h00)
            && (ls.count_seen != `COUNT_FULL);
        frame_word = frame_full ? fs.shift : ls.shift_seen;
    end

    // ------------------------------------------------------------
    // Link side: command decode and latch enables
    // ------------------------------------------------------------

    // Decoded command of the captured word and one enable per latch
    command_t cmd;
    logic apply_now;
    logic load_power;
    logic load_a;
    logic load_b;
    logic load_buf;
    logic xfer_b;
    logic load_mode;

    word_decode u_decode (
        .word(ls.word),
        .cmd(cmd)
    );

    // Power word overrides the select bits of the same word
    always_comb begin
        apply_now = ls.load_pend && !cmd.power_down;
        load_power = ls.load_pend && cmd.power_down;
    end

    // One enable per latch, from the two select bits
    always_comb begin
        // Nothing is enabled unless a word waits and is not a power word
        load_a = 1'b0;
        load_b = 1'b0;
        load_buf = 1'b0;
        xfer_b = 1'b0;
        load_mode = 1'b0;
        case (cmd.sel)
            SEL_B_AND_BUF: begin
                load_b = apply_now;
                load_buf = apply_now;
                load_mode = apply_now;
            end
            SEL_BUF_ONLY: begin
                load_buf = apply_now;
                load_mode = apply_now;
            end
            SEL_A_AND_XFER: begin
                load_a = apply_now;
                xfer_b = apply_now;
                load_mode = apply_now;
            end
            SEL_RESERVED: begin
                // Reserved code enables no latch, speed bit untouched
                load_mode = 1'b0;
            end
            default: begin
                load_mode = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Link side: latches on the rising serial clock
    // ------------------------------------------------------------

    // Capture a finished frame, apply it on the next rising edge
    always_comb begin
        next_ls = ls;
        // Copies of the falling edge state, read half a period later
        next_ls.shift_seen = fs.shift;
        next_ls.count_seen = fs.count;
        next_ls.load_pend = frame_full || frame_cut;
        if (frame_full || frame_cut) begin
            next_ls.word = frame_word;
        end
        // Power word: power-down only, other fields ignored
        if (load_power) begin
            next_ls.pd = 1'b1;
            next_ls.toggle = ~ls.toggle;
        end
        // Normal word: leave power-down, take the speed bit
        if (load_mode) begin
            next_ls.pd = 1'b0;
            next_ls.fast = cmd.fast;
            next_ls.toggle = ~ls.toggle;
        end
        // New code into the holding buffer and the converter latches
        if (load_buf) begin
            next_ls.buffer = cmd.code;
        end
        if (load_b) begin
            next_ls.hold_b = cmd.code;
        end
        if (load_a) begin
            next_ls.hold_a = cmd.code;
        end
        // Simultaneous update: the buffer moves into converter B
        if (xfer_b) begin
            next_ls.hold_b = ls.buffer;
        end
    end

    // Power-on clears every latch and the holding buffer
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            ls <= '0;
        end else begin
            ls <= next_ls;
        end
    end

    // ------------------------------------------------------------
    // Crossing: only the toggle passes two flip-flops
    // ------------------------------------------------------------

    // Toggle as seen after two system clock flip-flops
    logic tog_sync;

    // The held values stand still for several system clocks after
    // the toggle flips, so they are read without synchronising
    level_sync u_tog_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(ls.toggle),
        .q(tog_sync)
    );

    // ------------------------------------------------------------
    // System side: outputs latched on the synchronised toggle
    // ------------------------------------------------------------

    // Output registers and the last toggle value seen
    typedef struct packed {
        logic seen;
        logic [11:0] a;
        logic [11:0] b;
        logic fast;
        logic pd;
        logic tog;
    } sys_state_t;
    sys_state_t ss;
    sys_state_t next_ss;

    // Marks the clock in which a new word arrives
    logic new_word;

    // A change of the synchronised toggle marks an applied word
    always_comb begin
        new_word = (tog_sync != ss.seen);
    end

    // All outputs take the held values in one clock
    always_comb begin
        next_ss = ss;
        next_ss.seen = tog_sync;
        if (new_word) begin
            next_ss.a = ls.hold_a;
            next_ss.b = ls.hold_b;
            next_ss.fast = ls.fast;
            next_ss.pd = ls.pd;
            next_ss.tog = ~ss.tog;
        end
    end

    // Power-on clears the outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ss <= '0;
        end else begin
            ss <= next_ss;
        end
    end

    // ------------------------------------------------------------
    // Outputs: straight from the system side flip-flops
    // ------------------------------------------------------------

    // Converter codes
    assign code_a = ss.a;
    assign code_b = ss.b;

    // Mode flags
    assign fast_mode = ss.fast;
    assign power_down = ss.pd;

    // Update marker, flips once per applied word
    assign update_toggle = ss.tog;
endmodule : dual_dac_serial_word_decoder

// file: dac_host.sv
// Host serial port model that sends command words
`timescale 1ns/1ps
module dac_host (
    output logic sclk,
    output logic cs_b,
    output logic din
);
    // Clock idles high and stands still between frames
    initial begin
        sclk = 1'b1;
        cs_b = 1'b1;
        din = 1'b0;
    end
    // Send top n bits of w, then two closing pulses; 80 ns period
    task automatic send(input logic [15:0] w, input int n);
        #7 cs_b = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            din = w[i];
            #20 sclk = 1'b0;
            #40 sclk = 1'b1;
            #20;
        end
        cs_b = (n < 16);
        din = ~din;
        repeat (2) begin
            #40 sclk = 1'b0;
            #40 sclk = 1'b1;
        end
        #20 cs_b = 1'b1;
        #200;
    endtask : send
endmodule : dac_host

// file: dual_dac_serial_word_decoder_chk.sv
// Checker of the serial word decoder outputs
`timescale 1ns/1ps
module dac_word_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [11:0] code_a,
    input wire logic [11:0] code_b,
    input wire logic fast_mode,
    input wire logic power_down,
    input wire logic update_toggle
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_flip;
        $changed(update_toggle);
    endsequence
    a_code_a_flip: assert property ($changed(code_a) |-> s_flip)
        else $error("code_a moved without update");
    a_code_b_flip: assert property ($changed(code_b) |-> s_flip)
        else $error("code_b moved without update");
    a_fast_flip: assert property ($changed(fast_mode) |-> s_flip)
        else $error("fast_mode moved without update");
    a_power_flip: assert property ($changed(power_down) |-> s_flip)
        else $error("power_down moved without update");
    a_reset_zero: assert property ($rose(rst_b) |->
        {code_a, code_b, fast_mode, power_down, update_toggle} == 27'h0)
        else $error("outputs not clear after reset");
    a_power_codes: assert property ($rose(power_down) |->
        $stable(code_a) && $stable(code_b))
        else $error("codes changed on power word");
    a_power_mode: assert property ($rose(power_down) |->
        $stable(fast_mode))
        else $error("speed changed on power word");
    a_flip_spacing: assert property (s_flip |=>
        $stable(update_toggle)[*3])
        else $error("updates too close together");
endmodule : dac_word_chk
bind dual_dac_serial_word_decoder dac_word_chk u_chk (.clk, .rst_b,
    .code_a, .code_b, .fast_mode, .power_down, .update_toggle);

// file: dual_dac_serial_word_decoder_test.sv
// Testbench of the serial word decoder against a reference model
`timescale 1ns/1ps
module dual_dac_serial_word_decoder_test;
    logic clk, rst_b, sclk, cs_b, din;
    logic [11:0] code_a, code_b;
    logic fast_mode, power_down, update_toggle;
    int fails = 0;
    int total_checks = 0;
    int ea = 0, eb = 0, ebuf = 0, ef = 0, ep = 0, et = 0;
    logic [15:0] r;
    dac_host host (.sclk, .cs_b, .din);
    dual_dac_serial_word_decoder dut (.clk, .rst_b, .sclk, .cs_b, .din,
        .code_a, .code_b, .fast_mode, .power_down, .update_toggle);
    // System clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare tasks for codes and for flags
    task automatic chk12(input logic [11:0] g, input logic [11:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk12
    task automatic chk1(input logic g, input logic e);
        chk12({11'h0, g}, {11'h0, e});
    endtask : chk1
    task automatic check_all;
        chk12(code_a, 12'(ea));
        chk12(code_b, 12'(eb));
        chk1(fast_mode, ef[0]);
        chk1(power_down, ep[0]);
        chk1(update_toggle, et[0]);
    endtask : check_all
    // Send a word, update the reference model, then compare
    task automatic word(input logic [15:0] w, input int n);
        logic [15:0] v;
        v = (n < 16) ? (w >> (16 - n)) : w;
        host.send(w, n);
        if (v[13]) begin
            ep = 1;
            et ^= 1;
        end else if (!(v[15] && v[12])) begin
            ep = 0;
            ef = v[14];
            et ^= 1;
            case ({v[15], v[12]})
                2'b00: begin
                    eb = v[11:0];
                    ebuf = v[11:0];
                end
                2'b01: ebuf = v[11:0];
                default: begin
                    ea = v[11:0];
                    eb = ebuf;
                end
            endcase
        end
        repeat (2) @(negedge clk);
        check_all();
    endtask : word
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        rst_b = 1'b0;
        void'($urandom(57689));
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check_all();
        for (int s = 0; s < 8; s++) begin
            r = 16'($urandom);
            word({s[1], s[2], 1'b0, s[0], r[11:0]}, 16);
        end
        word(16'($urandom) | 16'h2000, 16);
        word(16'h1000, 16);
        word(16'($urandom), 12);
        repeat (6) word(16'($urandom), 16);
        summarize();
    end
endmodule : dual_dac_serial_word_decoder_test
